//--- src/ssf_pkg.sv
// package for the safe-side fifo and position register bank
package ssf_pkg;
    // register offsets
    localparam logic [7:0] OFS_STATUS = 8'h2D;
    localparam logic [7:0] OFS_FIFO_DATA = 8'h2E;
    localparam logic [7:0] OFS_MIRROR = 8'h2F;
    localparam logic [7:0] OFS_SHORT_MSG = 8'h37;
    localparam logic [7:0] OFS_ERR_CNT = 8'h38;
    localparam logic [7:0] OFS_ACC_LIMIT = 8'h39;
    localparam logic [7:0] OFS_DEV_HIGH = 8'h3A;
    localparam logic [7:0] OFS_DEV_LOW = 8'h3B;
    // status bit positions
    localparam int BIT_OVERFLOW = 3;
    localparam int BIT_EMPTY = 2;
    localparam int BIT_CODING_ERR = 1;
    localparam int BIT_CONTROL_SYM = 0;
    // fifo geometry
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    // pipe marker for the upper status nibble
    localparam logic [3:0] PIPE_STATUS_MARK = 4'h5;
    // reset values and limits
    localparam logic [7:0] ACC_LIMIT_RESET = 8'hFF;
    localparam logic [15:0] DEV_RESET = 16'hFFFF;
    localparam logic [4:0] ERR_CNT_MAX = 5'h1F;
    localparam logic [7:0] EMPTY_DATA = 8'h00;
    // 8b10b control symbol decoding, k30.7 is idle filler
    localparam logic [7:0] K_IDLE = 8'hFE;
    // one fifo entry
    typedef struct packed {
        logic coding_err;
        logic control_sym;
        logic [7:0] data;
    } ssf_entry_t;
    // incoming sensor-channel symbol
    typedef struct packed {
        logic valid;
        logic is_control;
        logic coding_err;
        logic [7:0] value;
    } ssf_symbol_t;
    // register access strobe group
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssf_access_t;
endpackage : ssf_pkg

//--- src/ssf_regs.sv
// safe-side sensor fifo, message result and fast-position register bank
// Function
// - eight-deep fifo, drop oldest, overflow flag bit3
// - status read clears overflow flag
// - empty read returns 00h, sets empty flag
// - empty flag updated on every data access, status access leaves it
// - per-byte coding error flag in bit1
// - per-byte control symbol flag in bit0
// - idle control symbol never enters fifo
// - control symbols stored as decoded byte values
// - data register local only when pipe disabled
// - status access latches matching data byte
// - fifo data and status ignore writes
// - mirror data answered at once, 8-bit
// - 5-bit consecutive error counter saturating 31
// - threshold write clamped, output when count exceeds
// - write-only acceleration limit, resets all ones
// - max deviation tracked, saturating, resets ffff
// - deviation writes load 16-bit threshold, one byte per write
// - unimplemented status and counter bits read zero
// - pipe status upper nibble forced 0101
`timescale 1ns/1ns
`default_nettype none
module ssf_regs
    import ssf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire ssf_access_t i_acc,              // local register access
    output logic [7:0] o_rdata,                 // read data, valid cycle after rd
    input wire logic i_serial_pipe_enable,      // pipe owns status and data
    input wire logic i_pipe_rd,                 // pipe read request pulse
    output logic [7:0] o_pipe_status,           // first pipe byte
    output logic [7:0] o_pipe_data,             // second pipe byte
    input wire ssf_symbol_t i_sym,              // received sensor symbol
    input wire logic [7:0] i_short_msg_result,  // short-message answer
    input wire logic [7:0] i_mirror_data,       // mirrored remote register value
    input wire logic i_fp_frame,                // fast-position transfer received
    input wire logic i_fp_error,                // that transfer had an error
    input wire logic i_est_active,              // position estimator running
    input wire logic [15:0] i_est_deviation,    // current absolute deviation
    output logic [7:0] o_acceleration_limit,    // clamp for the estimator
    output logic o_acc_thr_err,                 // error count above threshold
    output logic o_dev_thr_err                  // deviation above threshold
);
    // fifo storage and pointers
    ssf_entry_t mem [FIFO_DEPTH];
    ssf_entry_t next_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] rd_ptr, next_rd_ptr;
    logic [PTR_W:0] count, next_count;
    logic fifo_overflow_flag, next_fifo_overflow_flag;
    logic fifo_empty_flag, next_fifo_empty_flag;
    ssf_entry_t latched, next_latched;          // byte frozen by status access
    // registered read data and pipe bytes; each holds until replaced
    logic [7:0] rdata, next_rdata;
    logic [7:0] pipe_status, next_pipe_status;
    logic [7:0] pipe_data, next_pipe_data;
    // position state
    logic [4:0] err_cnt, next_err_cnt;
    logic [4:0] err_thr, next_err_thr;
    logic [7:0] acceleration_limit, next_acceleration_limit;
    logic [15:0] max_dev, next_max_dev;
    logic [15:0] dev_thr, next_dev_thr;
    logic [7:0] mirror_read_data, next_mirror_read_data;

    // decoded byte of a received symbol; control symbols already carry it
    function automatic logic is_idle(input ssf_symbol_t s);
        return s.is_control && (s.value == K_IDLE);
    endfunction

    // clamp an 8-bit write to the 5-bit range
    // a write above 31 still lands, just as the largest threshold
    function automatic logic [4:0] clamp5(input logic [7:0] v);
        return (v > 8'(ERR_CNT_MAX)) ? ERR_CNT_MAX : v[4:0];
    endfunction

    // status byte built from head entry and flags
    function automatic logic [7:0] status_byte(input logic [3:0] upper, input logic ovf,
                                               input logic emp, input ssf_entry_t e);
        return {upper, ovf, emp, e.coding_err, e.control_sym};
    endfunction

    // decode helpers, all recomputed at the top of the fifo process
    logic loc_rd, loc_wr;
    logic status_access, data_access;
    logic push;
    logic [PTR_W-1:0] wr_idx;
    logic pipe_take; // a pipe read the block honours
    ssf_entry_t head; // fifo output entry, zero when empty

    // order inside the process matters: status latch, then pop, then push;
    // a push into a full fifo overwrites the oldest slot and moves the
    // read pointer, so the set of the overflow flag wins over the clear
    // of a status read in the same cycle
    // fifo, flags and read path next state
    always_comb
    begin
        loc_rd = i_acc.rd;
        loc_wr = i_acc.wr;
        next_mem = mem;
        next_rd_ptr = rd_ptr;
        next_count = count;
        next_fifo_overflow_flag = fifo_overflow_flag;
        next_fifo_empty_flag = fifo_empty_flag;
        next_latched = latched;
        next_rdata = rdata;
        next_pipe_status = pipe_status;
        next_pipe_data = pipe_data;
        // a pipe read only counts while the pipe owns the fifo registers
        pipe_take = i_serial_pipe_enable && i_pipe_rd;
        // pipe enabled: status/data reached only through pipe reads
        status_access = pipe_take
                        || (!i_serial_pipe_enable && loc_rd && i_acc.addr == OFS_STATUS);
        data_access = pipe_take
                      || (!i_serial_pipe_enable && loc_rd && i_acc.addr == OFS_FIFO_DATA);
        push = i_sym.valid && !is_idle(i_sym);
        // an empty fifo reports no per-byte flags rather than a stale slot
        head = (count != '0) ? mem[rd_ptr] : '0;
        wr_idx = rd_ptr + count[PTR_W-1:0];
        // status access freezes head entry; reading also drops the overflow note
        if (status_access)
        begin
            next_latched = head;
            next_fifo_overflow_flag = 1'b0;
        end
        // data access pops; the byte itself comes from the latch or the pipe
        if (data_access)
        begin
            if (count == '0)
            begin
                next_fifo_empty_flag = 1'b1;
            end
            else
            begin
                next_fifo_empty_flag = 1'b0;
                next_rd_ptr = rd_ptr + 1'b1;
                next_count = count - 1'b1;
            end
        end
        // pipe read ships status and data of one snapshot, so the empty bit
        // already describes this very read and the pair always agrees
        if (pipe_take)
        begin
            next_pipe_status = status_byte(PIPE_STATUS_MARK, fifo_overflow_flag,
                                           next_fifo_empty_flag, head);
            next_pipe_data = (count == '0) ? EMPTY_DATA : head.data;
        end
        // push after pop so a full fifo that is read does not lose a byte
        if (push)
        begin
            wr_idx = next_rd_ptr + next_count[PTR_W-1:0];
            next_mem[wr_idx] =
                '{coding_err: i_sym.coding_err, control_sym: i_sym.is_control,
                  data: i_sym.value};
            // full: overwrite the oldest slot, step past it and note the loss
            if (next_count == (PTR_W+1)'(FIFO_DEPTH))
            begin
                next_rd_ptr = next_rd_ptr + 1'b1;
                next_fifo_overflow_flag = 1'b1;
            end
            else
            begin
                next_count = next_count + 1'b1;
            end
        end
        // local read mux; status upper nibble reads zero
        if (loc_rd)
        begin
            unique case (i_acc.addr)
                OFS_STATUS:
                    next_rdata = i_serial_pipe_enable ? 8'h00 :
                                 status_byte(4'h0, fifo_overflow_flag, fifo_empty_flag,
                                             head);
                OFS_FIFO_DATA:
                    next_rdata = (i_serial_pipe_enable || count == '0) ? EMPTY_DATA
                                 : latched.data;
                OFS_MIRROR: next_rdata = mirror_read_data;
                OFS_SHORT_MSG: next_rdata = i_short_msg_result;
                OFS_ERR_CNT: next_rdata = {3'b000, err_cnt};
                OFS_DEV_HIGH: next_rdata = max_dev[15:8];
                OFS_DEV_LOW: next_rdata = max_dev[7:0];
                default: next_rdata = 8'h00; // write-only or unmapped
            endcase
        end
        // writes to status and data fall through untouched
        if (loc_wr && (i_acc.addr == OFS_STATUS || i_acc.addr == OFS_FIFO_DATA))
        begin
            next_rdata = rdata;
        end
    end

    // fifo registers
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            for (int i = 0; i < FIFO_DEPTH; i++)
            begin
                mem[i] <= '0;
            end
            rd_ptr <= '0;
            count <= '0;
            fifo_overflow_flag <= 1'b0;
            // empty flag starts clear: no read has failed yet
            fifo_empty_flag <= 1'b0;
            latched <= '0;
            rdata <= 8'h00;
            pipe_status <= 8'h00;
            pipe_data <= 8'h00;
        end
        else
        begin
            mem <= next_mem;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            fifo_overflow_flag <= next_fifo_overflow_flag;
            fifo_empty_flag <= next_fifo_empty_flag;
            latched <= next_latched;
            rdata <= next_rdata;
            pipe_status <= next_pipe_status;
            pipe_data <= next_pipe_data;
        end
    end

    // fast-position and estimator next state
    always_comb
    begin
        next_err_cnt = err_cnt;
        next_err_thr = err_thr;
        next_acceleration_limit = acceleration_limit;
        next_max_dev = max_dev;
        next_dev_thr = dev_thr;
        // mirror copy is re-sampled every cycle; the read mux answers from it
        // without waiting on any remote transaction
        next_mirror_read_data = i_mirror_data;
        // consecutive error count, a good frame restarts it
        if (i_fp_frame)
        begin
            if (!i_fp_error)
            begin
                next_err_cnt = 5'h00;
            end
            // a bad frame adds one, stopping at the top instead of wrapping
            else if (err_cnt != ERR_CNT_MAX)
            begin
                next_err_cnt = err_cnt + 1'b1;
            end
        end
        // max deviation only moves while the estimator runs
        // it only grows; since reset loads it saturated at ffffh, nothing ever brings it down
        if (i_est_active && i_est_deviation > max_dev)
        begin
            next_max_dev = i_est_deviation;
        end
        // register writes
        if (i_acc.wr)
        begin
            unique case (i_acc.addr)
                OFS_ERR_CNT: next_err_thr = clamp5(i_acc.wdata);
                OFS_ACC_LIMIT: next_acceleration_limit = i_acc.wdata;
                // each deviation byte replaces only its own half of the threshold
                OFS_DEV_HIGH: next_dev_thr = {i_acc.wdata, dev_thr[7:0]};
                OFS_DEV_LOW: next_dev_thr = {dev_thr[15:8], i_acc.wdata};
                default: next_dev_thr = dev_thr; // read-only or unmapped
            endcase
        end
    end

    // position registers; max deviation starts saturated
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            err_cnt <= 5'h00;
            err_thr <= 5'h00;
            acceleration_limit <= ACC_LIMIT_RESET;
            max_dev <= DEV_RESET;
            // threshold zero at reset, so the deviation error shows until ffffh is written
            dev_thr <= 16'h0000;
            mirror_read_data <= 8'h00;
        end
        else
        begin
            err_cnt <= next_err_cnt;
            err_thr <= next_err_thr;
            acceleration_limit <= next_acceleration_limit;
            max_dev <= next_max_dev;
            dev_thr <= next_dev_thr;
            mirror_read_data <= next_mirror_read_data;
        end
    end

    // outputs
    assign o_rdata = rdata;
    assign o_pipe_status = pipe_status;
    assign o_pipe_data = pipe_data;
    assign o_acceleration_limit = acceleration_limit;
    // threshold outputs are plain compares of registered state, so they
    // change in the same cycle as the count or threshold register moves
    assign o_acc_thr_err = (err_cnt > err_thr);
    assign o_dev_thr_err = (max_dev > dev_thr);
endmodule // ssf_regs
`default_nettype wire

//--- sim/ssf_checker.sv
// port-level assertions for the safe-side register bank
`timescale 1ns/1ns
`default_nettype none
module ssf_checker
    import ssf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire ssf_access_t i_acc,
    input wire logic [7:0] o_rdata,
    input wire logic i_serial_pipe_enable,
    input wire logic i_pipe_rd,
    input wire logic [7:0] o_pipe_status,
    input wire logic [7:0] o_pipe_data,
    input wire logic [7:0] i_mirror_data,
    input wire logic [7:0] o_acceleration_limit
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // one local read strobe at a given offset
    sequence s_rd(logic [7:0] a); i_acc.rd && i_acc.addr == a; endsequence
    // a pipe read that the block takes
    sequence s_pipe; i_pipe_rd && i_serial_pipe_enable; endsequence
    property p_pipe_mark; s_pipe |=> o_pipe_status[7:4] == 4'h5; endproperty
    a_pipe_mark: assert property (p_pipe_mark) else $error("pipe marker wrong");
    property p_pipe_empty; s_pipe ##1 o_pipe_status[2] |-> o_pipe_data == 8'h00; endproperty
    a_pipe_empty: assert property (p_pipe_empty) else $error("empty pipe data");
    property p_pipe_hold;
        !(i_pipe_rd && i_serial_pipe_enable) |=> $stable(o_pipe_status) && $stable(o_pipe_data);
    endproperty
    a_pipe_hold: assert property (p_pipe_hold) else $error("pipe bytes moved");
    property p_rd_hold; !i_acc.rd |=> $stable(o_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_status_hi; s_rd(OFS_STATUS) ##0 !i_serial_pipe_enable |=> o_rdata[7:4] == 4'h0;
    endproperty
    a_status_hi: assert property (p_status_hi) else $error("status upper bits");
    property p_cnt_hi; s_rd(OFS_ERR_CNT) |=> o_rdata[7:5] == 3'b000; endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("counter upper bits");
    property p_pipe_off; s_rd(OFS_FIFO_DATA) ##0 i_serial_pipe_enable |=> o_rdata == 8'h00;
    endproperty
    a_pipe_off: assert property (p_pipe_off) else $error("data read while piped");
    property p_mirror;
        s_rd(OFS_MIRROR) ##0 $stable(i_mirror_data) |=> o_rdata == $past(i_mirror_data);
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror data late");
    property p_acc_wr; i_acc.wr && i_acc.addr == OFS_ACC_LIMIT |=>
        o_acceleration_limit == $past(i_acc.wdata); endproperty
    a_acc_wr: assert property (p_acc_wr) else $error("limit not loaded");
    property p_acc_keep; !(i_acc.wr && i_acc.addr == OFS_ACC_LIMIT) |=>
        $stable(o_acceleration_limit); endproperty
    a_acc_keep: assert property (p_acc_keep) else $error("limit moved");
endmodule // ssf_checker
`default_nettype wire

//--- sim/ssf_app_model.sv
// application-side model issuing register and pipe reads
`timescale 1ns/1ns
`default_nettype none
module ssf_app_model
    import ssf_pkg::*;
(
    input wire logic i_clk,
    output var ssf_access_t o_acc,
    output var logic o_pipe_rd
);
    initial
    begin
        o_acc = '0;
        o_pipe_rd = 1'b0;
    end
    // strobe set at a falling edge, taken at the rising edge between
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_acc = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge i_clk);
        // released lines flip so a stale address never looks held
        o_acc = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // one pipe read, status then data
    task automatic pipe_read;
        @(negedge i_clk);
        o_pipe_rd = 1'b1;
        @(negedge i_clk);
        o_pipe_rd = 1'b0;
    endtask
endmodule // ssf_app_model
`default_nettype wire

//--- sim/ssf_regs_tb.sv
// self-checking bench for the safe-side register bank
`timescale 1ns/1ns
`default_nettype none
module ssf_regs_tb
    import ssf_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    ssf_access_t acc;
    ssf_symbol_t sym = '0;
    logic pen = 1'b0, prd, fpf = 1'b0, fpe = 1'b0, esta = 1'b0, athr, dthr;
    logic [7:0] rdata, pst, pdt, alim, smr = 8'hC3, mir = 8'h96;
    logic [15:0] edev = 16'h0000;
    int num_errors = 0, compares = 0;
    // decoded control symbols in arrival order
    logic [7:0] kc [11] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC, 8'hFC,
        8'hF7, 8'hFB, 8'hFD};
    ssf_regs dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_acc(acc), .o_rdata(rdata),
        .i_serial_pipe_enable(pen), .i_pipe_rd(prd), .o_pipe_status(pst), .o_pipe_data(pdt),
        .i_sym(sym), .i_short_msg_result(smr), .i_mirror_data(mir), .i_fp_frame(fpf),
        .i_fp_error(fpe), .i_est_active(esta), .i_est_deviation(edev),
        .o_acceleration_limit(alim), .o_acc_thr_err(athr), .o_dev_thr_err(dthr));
    ssf_app_model app (.i_clk(i_clk), .o_acc(acc), .o_pipe_rd(prd));
    task automatic summarize;
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    // read with optional mask, for per-byte flags, which read zero when empty
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        app.access(1'b0, a, 8'h00);
        chk(rdata & m, e);
    endtask
    task automatic push(input logic c, input logic er, input logic [7:0] v);
        @(negedge i_clk);
        sym = '{valid: 1'b1, is_control: c, coding_err: er, value: v};
        @(negedge i_clk);
        sym.valid = 1'b0;
    endtask
    task automatic frames(input int n, input logic er);
        repeat (n)
        begin
            @(negedge i_clk);
            fpf = 1'b1;
            fpe = er;
            @(negedge i_clk);
            fpf = 1'b0;
        end
    endtask
    initial
    begin
        forever #50 i_clk = ~i_clk;
    end
    // hang guard, far beyond the normal run
    initial
    begin
        #3_000_000;
        num_errors++;
        $display("MISMATCH %0t run did not finish", $time);
        summarize();
    end
    initial
    begin
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        rdc(OFS_ERR_CNT, 8'h00);
        rdc(OFS_DEV_HIGH, 8'hFF);
        rdc(OFS_DEV_LOW, 8'hFF);
        chk(alim, 8'hFF);
        chk(dthr, 1'b1);
        rdc(OFS_FIFO_DATA, 8'h00);
        rdc(OFS_STATUS, 8'h04, 8'hFC);
        // idle filler first, then eleven symbols into eight places
        push(1'b1, 1'b0, 8'hFE);
        for (int i = 0; i < 11; i++)
            push(1'b1, i[0], kc[i]);
        for (int i = 3; i < 11; i++)
        begin
            rdc(OFS_STATUS, {4'h0, i == 3, i == 3, i[0], 1'b1});
            rdc(OFS_FIFO_DATA, kc[i]);
        end
        rdc(OFS_STATUS, 8'h00, 8'hFC);
        rdc(OFS_FIFO_DATA, 8'h00);
        rdc(OFS_STATUS, 8'h04, 8'hFC);
        app.access(1'b1, OFS_STATUS, 8'hFF);
        app.access(1'b1, OFS_FIFO_DATA, 8'hA5);
        push(1'b0, 1'b0, 8'h5A);
        rdc(OFS_STATUS, 8'h04);
        rdc(OFS_FIFO_DATA, 8'h5A);
        pen = 1'b1;
        push(1'b0, 1'b1, 8'h33);
        rdc(OFS_FIFO_DATA, 8'h00);
        app.pipe_read();
        chk(pst, 8'h52);
        chk(pdt, 8'h33);
        app.pipe_read();
        chk(pst, 8'h54);
        chk(pdt, 8'h00);
        pen = 1'b0;
        app.access(1'b1, OFS_ERR_CNT, 8'h03);
        frames(4, 1'b1);
        rdc(OFS_ERR_CNT, 8'h04);
        chk(athr, 1'b1);
        frames(1, 1'b0);
        rdc(OFS_ERR_CNT, 8'h00);
        chk(athr, 1'b0);
        app.access(1'b1, OFS_ERR_CNT, 8'h23);
        frames(33, 1'b1);
        rdc(OFS_ERR_CNT, 8'h1F);
        chk(athr, 1'b0);
        app.access(1'b1, OFS_ACC_LIMIT, 8'h8A);
        chk(alim, 8'h8A);
        rdc(OFS_ACC_LIMIT, 8'h00);
        rdc(8'h50, 8'h00);
        esta = 1'b1;
        edev = 16'h0100;
        app.access(1'b1, OFS_DEV_HIGH, 8'hFF);
        app.access(1'b1, OFS_DEV_LOW, 8'hFE);
        chk(dthr, 1'b1);
        app.access(1'b1, OFS_DEV_LOW, 8'hFF);
        chk(dthr, 1'b0);
        rdc(OFS_DEV_LOW, 8'hFF);
        app.access(1'b1, OFS_SHORT_MSG, 8'h00);
        rdc(OFS_SHORT_MSG, 8'hC3);
        rdc(OFS_MIRROR, 8'h96);
        summarize();
    end
endmodule // ssf_regs_tb
bind ssf_regs ssf_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_acc(i_acc),
    .o_rdata(o_rdata), .i_serial_pipe_enable(i_serial_pipe_enable), .i_pipe_rd(i_pipe_rd),
    .o_pipe_status(o_pipe_status), .o_pipe_data(o_pipe_data), .i_mirror_data(i_mirror_data),
    .o_acceleration_limit(o_acceleration_limit));
`default_nettype wire
